// [shared/ltc_defines.svh]
// Register offsets, field positions, reset values and constants of the compensation block
`ifndef LTC_DEFINES_SVH
`define LTC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LTC_CTRL_OFS       8'h00
`define LTC_SLOPE_OFS      8'h04
`define LTC_BASE_OFS       8'h08
`define LTC_TEMP_OFS       8'h0C
`define LTC_RESULT_OFS     8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define LTC_CTRL_EN_BIT    0
`define LTC_CTRL_EXT_BIT   1
`define LTC_SLOPE_STRIDE   4
`define LTC_RESULT_CODE_LSB 8

// ****************************************************************
// Reset values and temperature breakpoints
// ****************************************************************
`define LTC_BASE_RST       8'h00
`define LTC_TEMP_RST       8'h40
`define LTC_SLOPE_RST      3'h0
`define LTC_TD_A_END       8'h20
`define LTC_TD_B_END       8'h40
`define LTC_TD_C_END       8'h60
`define LTC_TD_D_END       8'h7E
`define LTC_TD_A_REF       10'sh020
`define LTC_TD_B_REF       10'sh040
`define LTC_TD_D_REF       10'sh060
`define LTC_SPAN_32        13'sh0020
`define LTC_SPAN_31        13'sh001F
`define LTC_ROUND_HALF     13'sh0004
`define LTC_FRAC_BITS      3
`define LTC_STEP_MV        30

`endif

// [shared/ltc_pkg.sv]
// Types shared by the temperature compensation block
package ltc_pkg;

    // Per-region slope selects, region a in the low slot
    typedef logic [3:0][2:0] ltc_slopes_t;

    // Captured AHB-Lite address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } ltc_aphase_t;

    // Registered datapath result
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] offset;
    } ltc_result_t;

endpackage

// [hw/ltc_comp.sv]
// Temperature compensation of the charge-pump voltage code with an AHB-Lite register slave
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "ltc_defines.svh"

module ltc_comp
    import ltc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  temp_sample,
    input  wire logic        temp_sample_valid,
    output logic      [7:0]  vlcd_code,
    output logic      [7:0]  temp_offset_code
);

    // ****************************************************************
    // Register map
    // ****************************************************************
    // One aligned 32-bit word per register, unused bits read as zero
    //
    //   00h  control
    //        bit 0   comp_enable_bit, gates the whole correction
    //        bit 1   external display supply, forces a zero offset
    //   04h  slope selects
    //        [2:0]   region_a_slope_select, coldest region
    //        [6:4]   region_b_slope_select
    //        [10:8]  region_c_slope_select
    //        [14:12] region_d_slope_select, hottest region
    //   08h  base voltage code
    //        [7:0]   base_voltage_code
    //   0Ch  temperature reading, read only
    //        [7:0]   temperature_reading as last loaded
    //   10h  result, read only
    //        [7:0]   temp_offset_code, two's complement
    //        [15:8]  final saturated voltage code
    //
    // Unmapped reads return zero, unmapped writes are dropped.
    // Writes to the read-only words are dropped as well, so a
    // stray write can never fake a reading or a result.
    //
    // Each slope command is one write of the whole slope word;
    // software wanting a single region changed must first read
    // the word back and merge. Kept this way to stay one decode.

    // ****************************************************************
    // Bus timing
    // ****************************************************************
    // Address phase captured at every edge with hready high.
    // Writes land at the data-phase edge, with hwdata standing.
    // Read data is prepared at the address edge, from current state,
    // and stands through the data phase.
    // Hazard: a read issued directly after a write to the same word
    // returns the old value; one idle cycle between them avoids it.
    // hreadyout and hresp are constant flops: no wait, never ERROR.
    // hsize is ignored, only whole-word accesses are expected.

    // ****************************************************************
    // Bus-side state
    // ****************************************************************
    ltc_aphase_t  aphase;
    ltc_aphase_t  next_aphase;
    logic         comp_enable_bit;
    logic         next_comp_enable_bit;
    logic         ext_supply;
    logic         next_ext_supply;
    ltc_slopes_t  slopes;
    ltc_slopes_t  next_slopes;
    logic [7:0]   base_voltage_code;
    logic [7:0]   next_base_voltage_code;
    logic [31:0]  next_hrdata;

    // ****************************************************************
    // Datapath state
    // ****************************************************************
    logic [7:0]   temperature_reading;
    logic [7:0]   next_temperature_reading;
    ltc_result_t  result;
    ltc_result_t  next_result;

    // Coefficients in eighths of a step, region a at index 0
    logic signed [4:0] coef [4];

    // ****************************************************************
    // Slope select decode
    // ****************************************************************
    // One decoder per region; eighths keep every entry an integer
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_coef
            always_comb begin
                case (slopes[gi])
                    3'h0:    coef[gi] = 5'sh00;
                    3'h1:    coef[gi] = -5'sh01;
                    3'h2:    coef[gi] = -5'sh02;
                    3'h3:    coef[gi] = -5'sh04;
                    3'h4:    coef[gi] = -5'sh0A;
                    3'h5:    coef[gi] = 5'sh01;
                    3'h6:    coef[gi] = 5'sh02;
                    3'h7:    coef[gi] = 5'sh04;
                    default: coef[gi] = 5'sh00;
                endcase
            end
        end
    endgenerate

    // ****************************************************************
    // AHB-Lite slave: next values
    // ****************************************************************
    // Zero wait states, so the address phase is captured every ready cycle
    always_comb begin
        next_aphase            = aphase;
        next_comp_enable_bit   = comp_enable_bit;
        next_ext_supply        = ext_supply;
        next_slopes            = slopes;
        next_base_voltage_code = base_voltage_code;
        next_hrdata            = hrdata;
        if (aphase.wr) begin
            case (aphase.addr)
                `LTC_CTRL_OFS: begin
                    next_comp_enable_bit = hwdata[`LTC_CTRL_EN_BIT];
                    next_ext_supply      = hwdata[`LTC_CTRL_EXT_BIT];
                end
                `LTC_SLOPE_OFS: begin
                    for (int i = 0; i < 4; i++) begin
                        next_slopes[i] = hwdata[i*`LTC_SLOPE_STRIDE +: 3];
                    end
                end
                `LTC_BASE_OFS: begin
                    next_base_voltage_code = hwdata[7:0];
                end
                default: begin
                end
            endcase
        end
        if (hready) begin
            next_aphase.wr   = hsel && htrans[1] && hwrite;
            next_aphase.rd   = hsel && htrans[1] && !hwrite;
            next_aphase.addr = {haddr[7:2], 2'b00};
            next_hrdata      = 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                case ({haddr[7:2], 2'b00})
                    `LTC_CTRL_OFS: begin
                        next_hrdata[`LTC_CTRL_EN_BIT]  = comp_enable_bit;
                        next_hrdata[`LTC_CTRL_EXT_BIT] = ext_supply;
                    end
                    `LTC_SLOPE_OFS: begin
                        for (int i = 0; i < 4; i++) begin
                            next_hrdata[i*`LTC_SLOPE_STRIDE +: 3] = slopes[i];
                        end
                    end
                    `LTC_BASE_OFS: begin
                        next_hrdata[7:0] = base_voltage_code;
                    end
                    `LTC_TEMP_OFS: begin
                        next_hrdata[7:0] = temperature_reading;
                    end
                    `LTC_RESULT_OFS: begin
                        next_hrdata[7:0] = result.offset;
                        next_hrdata[`LTC_RESULT_CODE_LSB +: 8] = result.code;
                    end
                    default: begin
                        next_hrdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // AHB-Lite slave: registers
    // ****************************************************************
    // Response is always OKAY and never stretched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase            <= '0;
            comp_enable_bit   <= 1'b0;
            ext_supply        <= 1'b0;
            slopes            <= {4{`LTC_SLOPE_RST}};
            base_voltage_code <= `LTC_BASE_RST;
            hrdata            <= 32'h0000_0000;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
        end else begin
            aphase            <= next_aphase;
            comp_enable_bit   <= next_comp_enable_bit;
            ext_supply        <= next_ext_supply;
            slopes            <= next_slopes;
            base_voltage_code <= next_base_voltage_code;
            hrdata            <= next_hrdata;
            hreadyout         <= 1'b1;
            hresp             <= 1'b0;
        end
    end

    // ****************************************************************
    // Region table
    // ****************************************************************
    // Reading    Offset in eighths of a step
    // 00h        -32*a - 32*b (floor of the scale)
    // 01h..20h   (reading - 32)*a - 32*b
    // 21h..40h   (reading - 64)*b
    // 41h..60h   (reading - 64)*c
    // 61h..7Eh   (reading - 96)*d + 32*c
    // 7Fh..FFh   31*d + 32*c, held
    //
    // The pieces join without jumps at 20h, 40h and 60h, so a
    // reading that wanders across a boundary moves the code by
    // at most one step per count and slope.
    //
    // Worst magnitude is 32*10 + 32*10 = 640 eighths at 00h, well inside
    // 13 signed bits; each product fits 10 signed bits.
    //
    // Rounding happens once, after the sum, so two half steps from
    // different regions never round twice in the same direction.
    // Trade-off: the offset is exact only to half a 30 mV step.
    //
    // The offset clamp to -128..127 cannot trigger with these
    // coefficients; it stays as a guard should the table grow.
    //
    // Sensor error passes straight into the code: the block has no
    // filter of its own and trusts whatever reading it is given.

    // ****************************************************************
    // Offset datapath: next values
    // ****************************************************************
    // Work in eighths of a 30 mV step, round once at the end
    logic signed [9:0]  td_s;
    logic signed [12:0] eighths;
    logic signed [12:0] rounded;
    logic signed [7:0]  offset_s;
    logic signed [9:0]  sum_s;

    always_comb begin
        next_temperature_reading = temperature_reading;
        if (temp_sample_valid) begin
            next_temperature_reading = temp_sample;
        end
        td_s = $signed({2'b00, temperature_reading});
        if (temperature_reading == 8'h00) begin
            // Floor of the scale shares the region a formula
            eighths = -(`LTC_SPAN_32 * coef[0]) - `LTC_SPAN_32 * coef[1];
        end else if (temperature_reading <= `LTC_TD_A_END) begin
            eighths = 13'((td_s - `LTC_TD_A_REF) * coef[0])
                      - `LTC_SPAN_32 * coef[1];
        end else if (temperature_reading <= `LTC_TD_B_END) begin
            eighths = 13'((td_s - `LTC_TD_B_REF) * coef[1]);
        end else if (temperature_reading <= `LTC_TD_C_END) begin
            eighths = 13'((td_s - `LTC_TD_B_REF) * coef[2]);
        end else if (temperature_reading <= `LTC_TD_D_END) begin
            eighths = 13'((td_s - `LTC_TD_D_REF) * coef[3])
                      + `LTC_SPAN_32 * coef[2];
        end else begin
            // Compensation stops here; hotter readings keep this value
            eighths = `LTC_SPAN_31 * coef[3] + `LTC_SPAN_32 * coef[2];
        end
        // Round half up to whole steps
        rounded = (eighths + `LTC_ROUND_HALF) >>> `LTC_FRAC_BITS;
        if (rounded > 13'sh007F) begin
            offset_s = 8'sh7F;
        end else if (rounded < -13'sh0080) begin
            offset_s = -8'sh80;
        end else begin
            offset_s = rounded[7:0];
        end
        // External supply or disabled means no correction at all
        if (!comp_enable_bit || ext_supply) begin
            offset_s = 8'sh00;
        end
        sum_s = $signed({2'b00, base_voltage_code}) + 10'(offset_s);
        next_result.offset = offset_s;
        if (sum_s < 10'sh000) begin
            next_result.code = 8'h00;
        end else if (sum_s > 10'sh0FF) begin
            next_result.code = 8'hFF;
        end else begin
            next_result.code = sum_s[7:0];
        end
    end

    // ****************************************************************
    // Output timing
    // ****************************************************************
    // A reading pulse is stored at the next edge and the outputs
    // follow one edge later. A register write reaches the outputs
    // one edge after its data phase. Between such events the
    // outputs hold, so the charge pump sees no glitches.
    // After reset the outputs show zero offset and a zero code,
    // since the base is cleared and the reading sits at 40h.

    // ****************************************************************
    // Offset datapath: registers
    // ****************************************************************
    // Result lags any change of the stored reading or settings by one clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temperature_reading <= `LTC_TEMP_RST;
            result              <= '0;
            vlcd_code           <= 8'h00;
            temp_offset_code    <= 8'h00;
        end else begin
            temperature_reading <= next_temperature_reading;
            result              <= next_result;
            vlcd_code           <= next_result.code;
            temp_offset_code    <= next_result.offset;
        end
    end

endmodule

// [verif/ltc_comp_chk.sv]
// Port assertions for the compensation block
`timescale 1ns/10ps
module ltc_comp_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [7:0]  temp_sample,
    input wire logic        temp_sample_valid,
    input wire logic [7:0]  vlcd_code,
    input wire logic [7:0]  temp_offset_code
);
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic take;
    // Transfer accepted at this edge
    assign take = hsel && hready && htrans[1];
    sequence s_rd(a);
        take && !hwrite && haddr == a;
    endsequence
    // Zero-wait OKAY slave
    property p_rdy; hreadyout; endproperty
    property p_ok; !hresp; endproperty
    // Reading 40h gives no offset whatever the slopes
    property p_off40; temp_sample_valid && temp_sample == 8'h40 |-> ##3 temp_offset_code == 8'h00;
    endproperty
    // Outputs move only after a new reading or a register write
    property p_offchg; $changed(temp_offset_code) |-> $past(temp_sample_valid, 2)
        || $past(temp_sample_valid, 3) || $past(take && hwrite, 3); endproperty
    property p_codechg; $changed(vlcd_code) |-> $past(temp_sample_valid, 2)
        || $past(temp_sample_valid, 3) || $past(take && hwrite, 3); endproperty
    property p_rdres; s_rd(8'h10) |=> hrdata == {16'h0000, $past(vlcd_code), $past(temp_offset_code)};
    endproperty
    property p_rdnone; hready && !(take && !hwrite) |=> hrdata == 32'h0; endproperty
    property p_unm; s_rd(8'h20) |=> hrdata == 32'h0; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state seen");
    a_ok: assert property (p_ok) else $error("error response seen");
    a_off40: assert property (p_off40) else $error("offset not zero at 40h");
    a_offchg: assert property (p_offchg) else $error("offset moved unprompted");
    a_codechg: assert property (p_codechg) else $error("code moved unprompted");
    a_rdres: assert property (p_rdres) else $error("result read differs from ports");
    a_rdnone: assert property (p_rdnone) else $error("read data left standing");
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind ltc_comp ltc_comp_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .temp_sample(temp_sample), .temp_sample_valid(temp_sample_valid),
    .vlcd_code(vlcd_code), .temp_offset_code(temp_offset_code));

// [verif/ltc_host.sv]
// Host model: single-word AHB-Lite master for configuration accesses
`timescale 1ns/10ps
module ltc_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [7:0]  haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [31:0] hwdata,
    output logic      [31:0] rd_data,
    output logic             rd_done,
    output logic             hung
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rd_done = 1'b0;
        hung = 1'b0;
    end
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 16) begin
            @(posedge hclk);
            n++;
        end
        if (n == 16) hung <= 1'b1;
    endtask
    // One whole-word transfer; writes carry slope commands and settings
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= w ? d : ~hwdata; // Reads toggle data so nothing stale looks valid
        wait_rdy();
        rd_data <= hrdata;
        rd_done <= !w;
        @(posedge hclk);
        rd_done <= 1'b0;
    endtask
endmodule

// [verif/tb.sv]
// Self-checking bench for the temperature compensation block
`timescale 1ns/10ps
module tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  temp_sample;
    logic        temp_sample_valid;
    logic [7:0]  vlcd_code;
    logic [7:0]  temp_offset_code;
    logic [31:0] rd_data;
    logic        rd_done;
    logic        hung;
    logic [31:0] exp_q[$];
    int          failures = 0;
    int          comparisons = 0;
    int          k[4];
    int          cf[8] = '{0, -1, -2, -4, -10, 1, 2, 4};
    logic [7:0]  tbl[10] = '{8'h00, 8'h20, 8'h21, 8'h40, 8'h41, 8'h60, 8'h61, 8'h7E, 8'h7F, 8'hFF};
    ltc_comp uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .temp_sample(temp_sample),
        .temp_sample_valid(temp_sample_valid), .vlcd_code(vlcd_code),
        .temp_offset_code(temp_offset_code));
    ltc_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .rd_data(rd_data), .rd_done(rd_done),
        .hung(hung));
    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (hung === 1'b1) failures++;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Scoreboard: oldest note meets each completed read
    always @(posedge hclk) begin
        if (rd_done === 1'b1) chk("hrdata", rd_data, exp_q.pop_front());
    end
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        exp_q.push_back(want);
        host.xfer(1'b0, a, 32'h0);
    endtask
    // Expected {code, offset}; slopes in eighths, rounded half up, then clamped
    function automatic logic [15:0] model(input int t, input int b, input logic on);
        int p;
        int c;
        if (t <= 32) p = (t - 32) * k[0] - 32 * k[1];
        else if (t <= 64) p = (t - 64) * k[1];
        else if (t <= 96) p = (t - 64) * k[2];
        else if (t <= 126) p = (t - 96) * k[3] + 32 * k[2];
        else p = 31 * k[3] + 32 * k[2];
        p = on ? (p + 4) >>> 3 : 0;
        p = p > 127 ? 127 : (p < -128 ? -128 : p);
        c = b + p;
        c = c > 255 ? 255 : (c < 0 ? 0 : c);
        return {c[7:0], p[7:0]};
    endfunction
    // One setting: new reading, enable, slope commands, base, then readback
    task automatic run_case(input int i);
        logic [7:0]  t;
        logic [7:0]  b;
        logic [1:0]  ctl;
        logic [15:0] sl;
        logic [15:0] m;
        t = i < 10 ? tbl[i] : 8'($urandom);
        b = i % 3 == 0 ? 8'hFF : (i % 3 == 1 ? 8'h00 : 8'($urandom));
        ctl = {i % 5 == 4, i % 4 != 3};
        sl = 16'h0;
        for (int x = 0; x < 4; x++) begin
            k[x] = cf[(i + x) % 8];
            sl[x*4 +: 3] = 3'((i + x) % 8);
        end
        m = model(t, b, ctl == 2'b01);
        temp_sample <= t;
        temp_sample_valid <= 1'b1;
        @(posedge hclk);
        temp_sample_valid <= 1'b0;
        host.xfer(1'b1, 8'h00, {30'h0, ctl});
        host.xfer(1'b1, 8'h04, {16'h0, sl});
        host.xfer(1'b1, 8'h08, {24'h0, b});
        host.xfer(1'b1, 8'h0C, {24'h0, ~t}); // Read-only: must not land
        rd(8'h0C, {24'h0, t});
        rd(8'h10, {16'h0, m});
        chk("ports", {16'h0, vlcd_code, temp_offset_code}, {16'h0, m});
    endtask
    // Reset, reset values, then every slope code in every region
    initial begin
        hresetn = 1'b0;
        temp_sample = 8'h00;
        temp_sample_valid = 1'b0;
        void'($urandom(32'h8807));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h40);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 24; i++) run_case(i);
        // Let the scoreboard see the last read before the verdict
        repeat (2) @(posedge hclk);
        tally_and_finish();
    end
    // Hang guard
    initial begin
        repeat (50000) @(posedge hclk);
        failures++;
        tally_and_finish();
    end
endmodule
